// ===== sbpr_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbpr_core_model (
	input  wire logic clk,
	input  wire logic long_bus_reset_active,
	input  wire logic far_reset,
	output var  logic bus_reset_event = 1'h0
);
	logic act_reg = 1'h0;
	// end of long reset, or a reset from elsewhere, reported as bus reset
	always @(posedge clk) begin
		act_reg <= long_bus_reset_active;
		bus_reset_event <= (act_reg & ~long_bus_reset_active)
			| far_reset;
	end
endmodule
`default_nettype wire

// ===== sbpr_defs.vh
`ifndef SBPR_DEFS_VH
`define SBPR_DEFS_VH
// register indices (byte address = 4 * index)
`define SBPR_IDX_NODE_ID       4'h0
`define SBPR_IDX_HOLDOFF_GAP   4'h1
`define SBPR_IDX_EXT_PORTS     4'h2
`define SBPR_IDX_SPEED_DELAY   4'h3
`define SBPR_IDX_LINK_POWER    4'h4
`define SBPR_IDX_EVENT_CTRL    4'h5
`define SBPR_IDX_RSVD_SIX      4'h6
`define SBPR_IDX_PAGE_SEL      4'h7
// paged range starts here
`define SBPR_IDX_PAGED_BASE    4'h8
// reserved pages
`define SBPR_PAGE_RSVD_LO      3'h2
`define SBPR_PAGE_RSVD_HI      3'h6
// constant fields
`define SBPR_EXT_CODE          3'h7
`define SBPR_PORT_COUNT        4'h2
`define SBPR_SPEED_CODE        3'h2
`define SBPR_DELAY_CODE        4'h0
`define SBPR_JITTER_CODE       3'h0
// reset values
`define SBPR_GAP_RESET         6'h3f
`define SBPR_LINK_CTRL_RESET   1'b1
// field positions
`define SBPR_PAGE_SEL_LSB      5
`define SBPR_PORT_SEL_LSB      0
// long bus reset duration
`define SBPR_LONG_RESET_US     166
`define SBPR_CLK_MHZ           200
`endif

// ===== sbpr_regs.v
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "sbpr_defs.vh"
module sbpr_regs #(
	parameter integer LONG_RESET_CYCLES =
		`SBPR_LONG_RESET_US * `SBPR_CLK_MHZ
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// phy core status
	input  wire        cable_power_pin,
	input  wire        self_id_done,
	input  wire [5:0]  self_id_phys_id,
	input  wire        tree_id_root,
	input  wire        phy_config_valid,
	input  wire [5:0]  phy_config_gap,
	input  wire        bus_busy,
	input  wire        bus_reset_event,
	// phy core control
	output reg         long_bus_reset_active,
	output wire        root_holdoff_out,
	output wire [5:0]  gap_count_out,
	output wire        node_id_valid,
	output wire [7:0]  page_sel_out
);

////////////////////////////////////////////////////////////////////////////
// pin synchroniser
reg [2:0] cps_sync_reg;
reg       cable_power_status_reg;
always @(posedge clk) begin
	if (rst) begin
		cps_sync_reg <= 3'h0;
	end else begin
		cps_sync_reg <= {cps_sync_reg[1:0], cable_power_pin};
	end
end

always @(posedge clk) begin
	if (rst) begin
		cable_power_status_reg <= 1'b0;
	end else if (cps_sync_reg[1] == cps_sync_reg[2]) begin
		cable_power_status_reg <= cps_sync_reg[2];
	end
end

////////////////////////////////////////////////////////////////////////////
// bus access
reg        ack_reg;
wire       acc = (avs_read | avs_write) & ~ack_reg;
assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
wire [3:0] idx = avs_address[5:2];
wire       in_range = (avs_address[1:0] == 2'b00);
wire       wr = avs_write & ack_reg & in_range;
wire [7:0] wd = avs_writedata[7:0];

always @(posedge clk) begin
	if (rst) begin
		ack_reg <= 1'b0;
	end else begin
		ack_reg <= acc;
	end
end

////////////////////////////////////////////////////////////////////////////
// register state
reg  [5:0]  node_phys_identifier_reg;
reg  [5:0]  node_phys_identifier_next;
reg         node_id_valid_reg;
reg         node_id_valid_next;
reg         root_reg;
reg         root_next;
reg         root_holdoff_reg;
reg         root_holdoff_next;
reg         long_bus_reset_request_reg;
reg         long_bus_reset_request_next;
reg  [5:0]  gap_count_reg;
reg  [5:0]  gap_count_next;
reg         gap_updated_reg;
reg         gap_updated_next;
reg         link_ctrl_reg;
reg         link_ctrl_next;
reg         contender_reg;
reg         contender_next;
reg  [2:0]  pwr_class_reg;
reg  [2:0]  pwr_class_next;
reg  [7:0]  event_ctrl_reg;
reg  [7:0]  event_ctrl_next;
reg  [7:0]  page_port_reg;
reg  [7:0]  page_port_next;
reg  [31:0] lbr_cnt_reg;
reg  [31:0] lbr_cnt_next;
reg         long_bus_reset_active_next;

////////////////////////////////////////////////////////////////////////////
// write strobes per register
wire wr_hold  = wr & (idx == `SBPR_IDX_HOLDOFF_GAP);
wire wr_power = wr & (idx == `SBPR_IDX_LINK_POWER);
wire wr_event = wr & (idx == `SBPR_IDX_EVENT_CTRL);
wire wr_page  = wr & (idx == `SBPR_IDX_PAGE_SEL);
wire gap_wr   = wr_hold;
wire gap_idle = ~gap_updated_reg & ~gap_wr & ~phy_config_valid;
// long bus reset waits for idle bus
wire lbr_start = long_bus_reset_request_reg & ~long_bus_reset_active
	& ~bus_busy;

////////////////////////////////////////////////////////////////////////////
// node identifier
always @* begin
	node_phys_identifier_next = node_phys_identifier_reg;
	node_id_valid_next = node_id_valid_reg;
	if (self_id_done) begin
		node_phys_identifier_next = self_id_phys_id;
		node_id_valid_next = 1'b1;
	end
	if (bus_reset_event) begin
		node_id_valid_next = 1'b0;
	end
end

always @(posedge clk) begin
	if (rst) begin
		node_phys_identifier_reg <= 6'h00;
		node_id_valid_reg <= 1'b0;
	end else begin
		node_phys_identifier_reg <= node_phys_identifier_next;
		node_id_valid_reg <= node_id_valid_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// root flag
always @* begin
	root_next = root_reg;
	if (tree_id_root) begin
		root_next = 1'b1;
	end
	if (bus_reset_event) begin
		root_next = 1'b0;
	end
end

always @(posedge clk) begin
	if (rst) begin
		root_reg <= 1'b0;
	end else begin
		root_reg <= root_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// root holdoff and long reset request
always @* begin
	root_holdoff_next = root_holdoff_reg;
	long_bus_reset_request_next = long_bus_reset_request_reg;
	if (lbr_start) begin
		long_bus_reset_request_next = 1'b0;
	end
	if (wr_hold) begin
		root_holdoff_next = wd[7];
		if (wd[6]) begin
			long_bus_reset_request_next = 1'b1;
		end
	end
	if (bus_reset_event) begin
		long_bus_reset_request_next = 1'b0;
	end
end

always @(posedge clk) begin
	if (rst) begin
		root_holdoff_reg <= 1'b0;
		long_bus_reset_request_reg <= 1'b0;
	end else begin
		root_holdoff_reg <= root_holdoff_next;
		long_bus_reset_request_reg <= long_bus_reset_request_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// gap count
always @* begin
	gap_count_next = gap_count_reg;
	gap_updated_next = gap_updated_reg;
	if (gap_wr) begin
		gap_count_next = wd[5:0];
		gap_updated_next = 1'b1;
	end else if (phy_config_valid) begin
		gap_count_next = phy_config_gap;
		gap_updated_next = 1'b1;
	end
	if (bus_reset_event) begin
		gap_updated_next = 1'b0;
		if (gap_idle) begin
			gap_count_next = `SBPR_GAP_RESET;
		end
	end
end

always @(posedge clk) begin
	if (rst) begin
		gap_count_reg <= `SBPR_GAP_RESET;
		gap_updated_reg <= 1'b0;
	end else begin
		gap_count_reg <= gap_count_next;
		gap_updated_reg <= gap_updated_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// link activity and power
always @* begin
	link_ctrl_next = link_ctrl_reg;
	contender_next = contender_reg;
	pwr_class_next = pwr_class_reg;
	if (wr_power) begin
		link_ctrl_next = wd[7];
		contender_next = wd[6];
		pwr_class_next = wd[2:0];
	end
end

always @(posedge clk) begin
	if (rst) begin
		link_ctrl_reg <= `SBPR_LINK_CTRL_RESET;
		contender_reg <= 1'b0;
		pwr_class_reg <= 3'h0;
	end else begin
		link_ctrl_reg <= link_ctrl_next;
		contender_reg <= contender_next;
		pwr_class_reg <= pwr_class_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// event control and page selection
always @* begin
	event_ctrl_next = event_ctrl_reg;
	page_port_next = page_port_reg;
	if (wr_event) begin
		event_ctrl_next = wd;
	end
	if (wr_page) begin
		page_port_next = {wd[7:5], 1'b0, wd[3:0]};
	end
end

always @(posedge clk) begin
	if (rst) begin
		event_ctrl_reg <= 8'h00;
		page_port_reg <= 8'h00;
	end else begin
		event_ctrl_reg <= event_ctrl_next;
		page_port_reg <= page_port_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// long bus reset timer, request consumed at start
always @* begin
	long_bus_reset_active_next = long_bus_reset_active;
	lbr_cnt_next = lbr_cnt_reg;
	if (lbr_start) begin
		long_bus_reset_active_next = 1'b1;
		lbr_cnt_next = LONG_RESET_CYCLES - 1;
	end else if (long_bus_reset_active) begin
		if (lbr_cnt_reg == 32'h0000_0000) begin
			long_bus_reset_active_next = 1'b0;
		end else begin
			lbr_cnt_next = lbr_cnt_reg - 32'h0000_0001;
		end
	end
end

always @(posedge clk) begin
	if (rst) begin
		long_bus_reset_active <= 1'b0;
		lbr_cnt_reg <= 32'h0000_0000;
	end else begin
		long_bus_reset_active <= long_bus_reset_active_next;
		lbr_cnt_reg <= lbr_cnt_next;
	end
end

////////////////////////////////////////////////////////////////////////////
// read mux
wire [2:0] page = page_port_reg[7:5];
wire       page_rsvd = (page >= `SBPR_PAGE_RSVD_LO)
	&& (page <= `SBPR_PAGE_RSVD_HI);
wire [7:0] node_val = {node_phys_identifier_reg, root_reg,
	cable_power_status_reg};
wire [7:0] hold_val = {root_holdoff_reg, long_bus_reset_request_reg,
	gap_count_reg};
wire [7:0] ext_val = {`SBPR_EXT_CODE, 1'b0, `SBPR_PORT_COUNT};
wire [7:0] speed_val = {`SBPR_SPEED_CODE, 1'b0, `SBPR_DELAY_CODE};
wire [7:0] power_val = {link_ctrl_reg, contender_reg, `SBPR_JITTER_CODE,
	pwr_class_reg};
reg  [7:0] rd;

always @* begin
	rd = 8'h00;
	if (!in_range) begin
		rd = 8'h00;
	end else if (idx == `SBPR_IDX_NODE_ID) begin
		rd = node_val;
	end else if (idx == `SBPR_IDX_HOLDOFF_GAP) begin
		rd = hold_val;
	end else if (idx == `SBPR_IDX_EXT_PORTS) begin
		rd = ext_val;
	end else if (idx == `SBPR_IDX_SPEED_DELAY) begin
		rd = speed_val;
	end else if (idx == `SBPR_IDX_LINK_POWER) begin
		rd = power_val;
	end else if (idx == `SBPR_IDX_EVENT_CTRL) begin
		rd = event_ctrl_reg;
	end else if (idx == `SBPR_IDX_RSVD_SIX) begin
		rd = 8'h00;
	end else if (idx == `SBPR_IDX_PAGE_SEL) begin
		rd = page_port_reg;
	end else if (page_rsvd) begin
		rd = 8'h00;
	end else begin
		rd = 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////////
// read data register
always @(posedge clk) begin
	if (rst) begin
		avs_readdata <= 32'h0000_0000;
	end else if (acc && avs_read) begin
		avs_readdata <= {24'h00_0000, rd};
	end
end

////////////////////////////////////////////////////////////////////////////
// core side copies
assign root_holdoff_out = root_holdoff_reg;
assign gap_count_out = gap_count_reg;
assign node_id_valid = node_id_valid_reg;
assign page_sel_out = page_port_reg;

endmodule
`default_nettype wire

// ===== sbpr_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module sbpr_regs_props #(parameter integer LONG_RESET_CYCLES = 20) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// register bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// core side
	input wire logic        bus_busy,
	input wire logic        phy_config_valid,
	input wire logic [5:0]  phy_config_gap,
	input wire logic [5:0]  gap_count_out,
	input wire logic        long_bus_reset_active
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	logic [15:0] len_reg;
	wire         req = avs_read | avs_write;
	wire         rd_ok = avs_read & ~avs_waitrequest;
	wire  [3:0]  idx = avs_address[5:2];
	// cycles spent in long bus reset
	always_ff @(posedge clk)
		len_reg <= long_bus_reset_active ? len_reg + 16'h0001 : 16'h0000;
	wait_first_a:
		assert property (req && !$past(req) |-> avs_waitrequest)
		else $error("request answered at once");
	answer_one_a:
		assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	rsvd_zero_a:
		assert property (rd_ok && (idx == 4'h6 || idx[3]) |->
			avs_readdata == 32'h0000_0000)
		else $error("reserved read not zero");
	const_codes_a:
		assert property (rd_ok && idx[3:1] == 3'h1 |-> avs_readdata ==
			(idx[0] ? 32'h0000_0040 : 32'h0000_00e2))
		else $error("constant register wrong");
	gap_reset_a:
		assert property ($fell(rst) |-> gap_count_out == 6'h3f)
		else $error("gap count reset wrong");
	gap_load_a:
		assert property (phy_config_valid |=>
			gap_count_out == $past(phy_config_gap))
		else $error("gap count not loaded");
	busy_defer_a:
		assert property ($rose(long_bus_reset_active) |-> !$past(bus_busy))
		else $error("long reset during traffic");
	long_len_a:
		assert property ($fell(long_bus_reset_active) |->
			len_reg == LONG_RESET_CYCLES)
		else $error("long reset length wrong");
endmodule
bind sbpr_regs sbpr_regs_props #(
	.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) sbpr_regs_props_i (.*);
`default_nettype wire

// ===== sbpr_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
	err_total++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module sbpr_regs_tb_top;
	logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, far_reset = 0;
	logic        cable_power_pin = 1, self_id_done = 0, tree_id_root = 0;
	logic        phy_config_valid = 0, bus_busy = 0;
	logic [5:0]  avs_address = 0, self_id_phys_id = 6'h2a, phy_config_gap = 0;
	logic [31:0] avs_writedata = 0, d;
	wire  logic [31:0] avs_readdata;
	wire  logic [7:0]  page_sel_out;
	wire  logic [5:0]  gap_count_out;
	wire  logic        avs_waitrequest, bus_reset_event, long_bus_reset_active;
	wire  logic        root_holdoff_out, node_id_valid;
	int                err_total = 0, tests_run = 0;
	sbpr_regs #(.LONG_RESET_CYCLES(20)) sbpr_regs_i (.*);
	sbpr_core_model sbpr_core_model_i (.*);
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input bit wr, input [3:0] i, input [7:0] v);
		@(posedge clk);
		avs_address <= {i, 2'h0};
		avs_writedata <= {24'h00_0000, v};
		avs_read <= !wr;
		avs_write <= wr;
		do @(negedge clk); while (avs_waitrequest !== 1'h0);
		@(posedge clk);
		d = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask
	task automatic ck(input [3:0] i, input [7:0] e);
		xfer(0, i, 8'h00);
		`CHK($sformatf("reg %0h", i), {24'h00_0000, e}, d)
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic long_end;
		wait (long_bus_reset_active === 1'h1);
		wait (long_bus_reset_active === 1'h0);
		repeat (4) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		ck(4'h1, 8'h3f);
		ck(4'h4, 8'h80);
		ck(4'h6, 8'h00);
		for (int p = 0; p < 8; p++) begin
			xfer(1, 4'h7, 8'(p << 5));
			ck(4'h7, 8'(p << 5));
			ck(4'(8 + p), 8'h00);
			ck(4'h2, 8'he2);
		end
		`CHK("page out", 8'he0, page_sel_out)
		ck(4'h3, 8'h40);
		@(posedge clk) self_id_done <= 1'h1;
		@(posedge clk) self_id_done <= 1'h0;
		tree_id_root <= 1'h1;
		@(posedge clk) tree_id_root <= 1'h0;
		ck(4'h0, 8'hab);
		`CHK("id valid", 1'h1, node_id_valid)
		cable_power_pin <= 1'h0;
		repeat (6) @(posedge clk);
		ck(4'h0, 8'haa);
		xfer(1, 4'h1, 8'h15);
		ck(4'h1, 8'h15);
		@(posedge clk) phy_config_gap <= 6'h0a;
		phy_config_valid <= 1'h1;
		@(posedge clk) phy_config_valid <= 1'h0;
		bus_busy <= 1'h1;
		xfer(1, 4'h1, 8'hca);
		repeat (12) @(posedge clk);
		`CHK("long reset", 1'h0, long_bus_reset_active)
		bus_busy <= 1'h0;
		long_end;
		ck(4'h1, 8'h8a);
		ck(4'h0, 8'ha8);
		`CHK("root", 1'h0, d[1])
		`CHK("id valid", 1'h0, node_id_valid)
		@(posedge clk) far_reset <= 1'h1;
		@(posedge clk) far_reset <= 1'h0;
		repeat (4) @(posedge clk);
		ck(4'h1, 8'hbf);
		`CHK("holdoff", 1'h1, root_holdoff_out)
		final_report;
	end
	initial begin
		#20000;
		err_total++;
		final_report;
	end
endmodule
`default_nettype wire
